// *** rtl/dtc_map.svh ***
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define DTC_IDX_CTRL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_CNT0_LO 8'h8a
`define DTC_IDX_CNT1_LO 8'h8b
`define DTC_IDX_CNT0_HI 8'h8c
`define DTC_IDX_CNT1_HI 8'h8d
`define DTC_IDX_ACK 8'h8e
`define DTC_IDX_LSB 2
`define DTC_IDX_MSB 9
`define DTC_PAGE_LSB 10

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DTC_CTRL_OVF1 7
`define DTC_CTRL_RUN1 6
`define DTC_CTRL_OVF0 5
`define DTC_CTRL_RUN0 4
`define DTC_CTRL_XFLAG1 3
`define DTC_CTRL_XEDGE1 2
`define DTC_CTRL_XFLAG0 1
`define DTC_CTRL_XEDGE0 0
`define DTC_CTRL_STEP 2

// ----------------------------------------------------------------------
// Mode register fields and codes
// ----------------------------------------------------------------------
`define DTC_MODE_GATE0 3
`define DTC_MODE_CT0 2
`define DTC_MODE_M_LSB0 0
`define DTC_MODE_STEP 4
`define DTC_MODE_13BIT 2'b00
`define DTC_MODE_16BIT 2'b01

// ----------------------------------------------------------------------
// Vector acknowledge register fields
// ----------------------------------------------------------------------
`define DTC_ACK_OVF1 3
`define DTC_ACK_OVF0 2
`define DTC_ACK_XFLAG1 1
`define DTC_ACK_XFLAG0 0

// ----------------------------------------------------------------------
// Reset values, prescaler, timing and responses
// ----------------------------------------------------------------------
`define DTC_CTRL_RESET 8'h00
`define DTC_MODE_RESET 8'h00
`define DTC_PRE_ONES 5'h1f
`define DTC_MC_CLKS 12
`define DTC_RESP_OKAY 2'b00
`define DTC_RESP_SLVERR 2'b10

`endif

// *** rtl/dtc_pkg.sv ***
package dtc_pkg;

   // One timer's register pair
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } dtc_count_type;

   // External pins, all synchronous to aclk
   typedef struct packed {
      logic ext_irq_pin_one_n;
      logic ext_irq_pin_zero_n;
      logic count_input_pin_one;
      logic count_input_pin_zero;
   } dtc_pins_type;

   typedef enum logic [1:0] {DTC_WR_TAKE = 2'b01, DTC_WR_RESP = 2'b10} dtc_wr_type;
   typedef enum logic [1:0] {DTC_RD_IDLE = 2'b01, DTC_RD_RESP = 2'b10} dtc_rd_type;

   // Whole state of the block
   typedef struct packed {
      dtc_count_type [1:0] tmr;
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [7:0] presc;
      logic mtick;
      logic [1:0] cnt_prev;
      logic [1:0] irq_prev;
      dtc_wr_type wr;
      dtc_rd_type rd;
      logic aw_full;
      logic aw_hit;
      logic [7:0] aw_idx;
      logic w_full;
      logic [7:0] wdata;
      logic wstrb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
   } dtc_state_type;

endpackage

// *** rtl/dtc_top.sv ***
// Notes on behaviour
// R1 - Each timer is a high and low byte, split or joined by mode
// R2 - Timer 1 overflow flag set on overflow, cleared on vector acknowledge
// R3 - Timer 1 run enable starts and stops timer 1
// R4 - Timer 0 overflow flag set on overflow, cleared on vector acknowledge
// R5 - Timer 0 run enable starts and stops timer 0
// R6 - Irq 1 flag: falling edge or low level; edge flag cleared by acknowledge
// R7 - Irq 1 trigger select: 1 falling edge, 0 low level
// R8 - Irq 0 flag: falling edge or low level; edge flag cleared by acknowledge
// R9 - Irq 0 trigger select: 1 falling edge, 0 low level
// R10 - Irq flag and trigger bits never touch the timers
// R11 - Both timers behave the same
// R12 - Mode 0: 13-bit count, low five bits prescale by 32
// R13 - Wrap from all ones to zero sets the overflow flag
// R14 - Counting needs run set and gate clear or irq pin high
// R15 - Setting run leaves the count untouched
// R16 - Mode 1: full 16-bit count
// R17 - Mode code 00 is 13-bit, 01 is 16-bit
// R18 - Counter select: 1 counts pin falls, 0 counts internal clock
// R19 - Gate set: count only while irq pin high and run set
// R20 - Timer counts machine cycles of twelve clocks, counter counts pin falls
// R21 - Count registers writable any time, effective next counting cycle
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "dtc_map.svh"

module dtc_top #(
   parameter int ADDR_W = 12,
   parameter int MC_CLKS = `DTC_MC_CLKS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire dtc_pkg::dtc_pins_type pins
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (ADDR_W <= `DTC_PAGE_LSB) begin : g_bad_addr
      $error("ADDR_W too small for the register map");
   end
   if (MC_CLKS < 2 || MC_CLKS > 256) begin : g_bad_mc
      $error("MC_CLKS must lie in 2..256");
   end

   // ----------------------------------------------------------------------
   // State and helpers
   // ----------------------------------------------------------------------
   dtc_pkg::dtc_state_type st;
   dtc_pkg::dtc_state_type next_st;
   logic do_write;
   logic wr_en;
   logic [1:0] tick;
   logic [1:0] ovf;
   logic [1:0] cnt_pin;
   logic [1:0] irq_pin;

   // Pin vectors indexed by timer number
   assign cnt_pin = {pins.count_input_pin_one, pins.count_input_pin_zero};
   assign irq_pin = {pins.ext_irq_pin_one_n, pins.ext_irq_pin_zero_n};

   // Outputs straight from the state flops
   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = {24'h000000, st.rdata};
   assign s_axi_rresp = st.rresp;

   // Index decodes to a mapped register
   function automatic logic dtc_mapped(input logic [7:0] idx);
      dtc_mapped = (idx >= `DTC_IDX_CTRL) && (idx <= `DTC_IDX_ACK);
   endfunction

   // Read mux over current state; acknowledge register reads zero
   function automatic logic [7:0] dtc_read(input dtc_pkg::dtc_state_type s,
                                          input logic [7:0] idx);
      case (idx)
         `DTC_IDX_CTRL: dtc_read = s.ctrl;
         `DTC_IDX_MODE: dtc_read = s.mode;
         `DTC_IDX_CNT0_LO: dtc_read = s.tmr[0].lo;
         `DTC_IDX_CNT1_LO: dtc_read = s.tmr[1].lo;
         `DTC_IDX_CNT0_HI: dtc_read = s.tmr[0].hi;
         `DTC_IDX_CNT1_HI: dtc_read = s.tmr[1].hi;
         default: dtc_read = 8'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      logic run;
      logic gate;
      logic ctsel;
      logic [1:0] md;
      logic src;
      logic carry;
      logic tmr_wr;
      logic [7:0] ridx;
      run = 1'b0;
      gate = 1'b0;
      ctsel = 1'b0;
      md = `DTC_MODE_13BIT;
      src = 1'b0;
      carry = 1'b0;
      tmr_wr = 1'b0;
      ridx = 8'h00;
      next_st = st;
      do_write = 1'b0;
      tick = 2'b00;
      ovf = 2'b00;

      // Machine cycle prescaler, one pulse every MC_CLKS clocks
      if (st.presc == 8'(MC_CLKS - 1)) begin // see R20
         next_st.presc = 8'h00;
         next_st.mtick = 1'b1;
      end else begin
         next_st.presc = st.presc + 8'h01;
         next_st.mtick = 1'b0;
      end

      // Pin history for falling edge detection
      next_st.cnt_prev = cnt_pin;
      next_st.irq_prev = irq_pin;

      // Write channel: address and data taken in either order
      case (st.wr)
         dtc_pkg::DTC_WR_TAKE: begin
            if (s_axi_awvalid && st.awready) begin
               next_st.aw_full = 1'b1;
               next_st.awready = 1'b0;
               next_st.aw_idx = s_axi_awaddr[`DTC_IDX_MSB:`DTC_IDX_LSB];
               next_st.aw_hit = (s_axi_awaddr[ADDR_W-1:`DTC_PAGE_LSB] == '0);
            end
            if (s_axi_wvalid && st.wready) begin
               next_st.w_full = 1'b1;
               next_st.wready = 1'b0;
               next_st.wdata = s_axi_wdata[7:0];
               next_st.wstrb0 = s_axi_wstrb[0];
            end
            if (st.aw_full && st.w_full) begin
               do_write = 1'b1;
               next_st.aw_full = 1'b0;
               next_st.w_full = 1'b0;
               next_st.bvalid = 1'b1;
               next_st.bresp = (st.aw_hit && dtc_mapped(st.aw_idx)) ?
                               `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
               next_st.wr = dtc_pkg::DTC_WR_RESP;
            end
         end
         dtc_pkg::DTC_WR_RESP: begin
            if (s_axi_bready) begin
               next_st.bvalid = 1'b0;
               next_st.awready = 1'b1;
               next_st.wready = 1'b1;
               next_st.wr = dtc_pkg::DTC_WR_TAKE;
            end
         end
         default: begin
            next_st.wr = dtc_pkg::DTC_WR_TAKE;
         end
      endcase

      // Read channel: one read under way at a time
      case (st.rd)
         dtc_pkg::DTC_RD_IDLE: begin
            if (s_axi_arvalid && st.arready) begin
               ridx = s_axi_araddr[`DTC_IDX_MSB:`DTC_IDX_LSB];
               next_st.arready = 1'b0;
               next_st.rvalid = 1'b1;
               if ((s_axi_araddr[ADDR_W-1:`DTC_PAGE_LSB] == '0) && dtc_mapped(ridx)) begin
                  next_st.rdata = dtc_read(st, ridx);
                  next_st.rresp = `DTC_RESP_OKAY;
               end else begin
                  next_st.rdata = 8'h00;
                  next_st.rresp = `DTC_RESP_SLVERR;
               end
               next_st.rd = dtc_pkg::DTC_RD_RESP;
            end
         end
         dtc_pkg::DTC_RD_RESP: begin
            if (s_axi_rready) begin
               next_st.rvalid = 1'b0;
               next_st.arready = 1'b1;
               next_st.rd = dtc_pkg::DTC_RD_IDLE;
            end
         end
         default: begin
            next_st.rd = dtc_pkg::DTC_RD_IDLE;
         end
      endcase

      // Software register writes; run bits only gate, counts stay put
      wr_en = do_write && st.aw_hit && st.wstrb0 && dtc_mapped(st.aw_idx);
      if (wr_en) begin
         case (st.aw_idx)
            `DTC_IDX_CTRL: next_st.ctrl = st.wdata; // see R3 see R5 see R15
            `DTC_IDX_MODE: next_st.mode = st.wdata; // see R17
            `DTC_IDX_CNT0_LO: next_st.tmr[0].lo = st.wdata; // see R21
            `DTC_IDX_CNT1_LO: next_st.tmr[1].lo = st.wdata;
            `DTC_IDX_CNT0_HI: next_st.tmr[0].hi = st.wdata;
            `DTC_IDX_CNT1_HI: next_st.tmr[1].hi = st.wdata;
            `DTC_IDX_ACK: begin
               // Vector acknowledge clears flags; edge-only for irq flags
               if (st.wdata[`DTC_ACK_OVF1]) next_st.ctrl[`DTC_CTRL_OVF1] = 1'b0; // see R2
               if (st.wdata[`DTC_ACK_OVF0]) next_st.ctrl[`DTC_CTRL_OVF0] = 1'b0; // see R4
               if (st.wdata[`DTC_ACK_XFLAG1]) next_st.ctrl[`DTC_CTRL_XFLAG1] = 1'b0; // see R6
               if (st.wdata[`DTC_ACK_XFLAG0]) next_st.ctrl[`DTC_CTRL_XFLAG0] = 1'b0; // see R8
            end
            default: begin
            end
         endcase
      end

      // Two identical timers; irq flag bits take no part here
      for (int i = 0; i < 2; i++) begin // see R11 see R10
         run = st.ctrl[`DTC_CTRL_RUN0 + `DTC_CTRL_STEP * i];
         gate = st.mode[`DTC_MODE_GATE0 + `DTC_MODE_STEP * i];
         ctsel = st.mode[`DTC_MODE_CT0 + `DTC_MODE_STEP * i];
         md = st.mode[`DTC_MODE_M_LSB0 + `DTC_MODE_STEP * i +: 2];
         src = ctsel ? (st.cnt_prev[i] && !cnt_pin[i]) : st.mtick; // see R18 see R20
         tmr_wr = wr_en && ((st.aw_idx == `DTC_IDX_CNT0_LO + 8'(i)) ||
                            (st.aw_idx == `DTC_IDX_CNT0_HI + 8'(i)));
         // A software write to the pair replaces this counting step
         tick[i] = run && (!gate || irq_pin[i]) && src && !tmr_wr; // see R14 see R19
         carry = 1'b0;
         if (tick[i] && md == `DTC_MODE_13BIT) begin
            // Low five bits prescale by 32, upper three left alone
            carry = (st.tmr[i].lo[4:0] == `DTC_PRE_ONES); // see R12
            next_st.tmr[i].lo[4:0] = st.tmr[i].lo[4:0] + 5'h01;
            if (carry) begin
               next_st.tmr[i].hi = st.tmr[i].hi + 8'h01;
            end
            ovf[i] = carry && (st.tmr[i].hi == 8'hff);
         end else if (tick[i] && md == `DTC_MODE_16BIT) begin
            // Full 16-bit cascade, no prescaler
            next_st.tmr[i] = st.tmr[i] + 16'h0001; // see R16 see R1
            ovf[i] = (st.tmr[i] == 16'hffff);
         end
         // Overflow sets the flag; set wins over acknowledge
         if (ovf[i]) begin
            next_st.ctrl[`DTC_CTRL_OVF0 + `DTC_CTRL_STEP * i] = 1'b1; // see R13 see R2 see R4
         end
      end

      // External interrupt flags, edge or level per trigger select
      for (int i = 0; i < 2; i++) begin
         if (st.ctrl[`DTC_CTRL_XEDGE0 + `DTC_CTRL_STEP * i]) begin // see R7 see R9
            if (st.irq_prev[i] && !irq_pin[i]) begin
               next_st.ctrl[`DTC_CTRL_XFLAG0 + `DTC_CTRL_STEP * i] = 1'b1; // see R6 see R8
            end
         end else begin
            next_st.ctrl[`DTC_CTRL_XFLAG0 + `DTC_CTRL_STEP * i] = !irq_pin[i]; // see R6 see R8
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.ctrl <= `DTC_CTRL_RESET;
         st.mode <= `DTC_MODE_RESET;
         st.wr <= dtc_pkg::DTC_WR_TAKE;
         st.rd <= dtc_pkg::DTC_RD_IDLE;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.irq_prev <= 2'b11;
         st.cnt_prev <= 2'b00;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking dtc_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn || !ce);

   // Stopped timer 0 holds its count
   property p_hold0; // see R5
      (!st.ctrl[`DTC_CTRL_RUN0] && !wr_en) |=> $stable(st.tmr[0]);
   endproperty
   a_hold0: assert property (p_hold0) else $error("timer 0 moved while stopped");

   // Stopped timer 1 holds its count
   property p_hold1; // see R3
      (!st.ctrl[`DTC_CTRL_RUN1] && !wr_en) |=> $stable(st.tmr[1]);
   endproperty
   a_hold1: assert property (p_hold1) else $error("timer 1 moved while stopped");

   // Gated timer 0 holds while its irq pin is low
   property p_gate0; // see R14
      (st.ctrl[`DTC_CTRL_RUN0] && st.mode[`DTC_MODE_GATE0] && !pins.ext_irq_pin_zero_n
       && !wr_en) |=> $stable(st.tmr[0]);
   endproperty
   a_gate0: assert property (p_gate0) else $error("gated timer 0 counted");

   // 16-bit wrap of timer 0 sets its flag and clears the pair
   sequence s_full16;
      tick[0] && st.mode[1:0] == `DTC_MODE_16BIT && st.tmr[0] == 16'hffff;
   endsequence
   property p_ovf16; // see R13
      s_full16 |=> st.ctrl[`DTC_CTRL_OVF0] && st.tmr[0] == 16'h0000;
   endproperty
   a_ovf16: assert property (p_ovf16) else $error("16-bit overflow wrong");

   // 13-bit wrap of timer 1 sets its flag
   sequence s_full13;
      tick[1] && st.mode[5:4] == `DTC_MODE_13BIT && st.tmr[1].hi == 8'hff
      && st.tmr[1].lo[4:0] == `DTC_PRE_ONES;
   endsequence
   property p_wrap13; // see R12
      s_full13 |=> st.ctrl[`DTC_CTRL_OVF1] && st.tmr[1].hi == 8'h00
                   && st.tmr[1].lo[4:0] == 5'h00;
   endproperty
   a_wrap13: assert property (p_wrap13) else $error("13-bit overflow wrong");

   // Prescaler below 31 leaves the high byte alone
   property p_carry13; // see R1
      (tick[0] && st.mode[1:0] == `DTC_MODE_13BIT && st.tmr[0].lo[4:0] != `DTC_PRE_ONES)
      |=> $stable(st.tmr[0].hi);
   endproperty
   a_carry13: assert property (p_carry13) else $error("high byte stepped early");

   // Machine cycle pulse follows the last prescaler count and lasts one clock
   property p_mc; // see R20
      (st.presc == 8'(MC_CLKS - 1)) |=> st.mtick ##1 !st.mtick;
   endproperty
   a_mc: assert property (p_mc) else $error("machine cycle pulse wrong");

   // Counter mode steps timer 0 by one on a pin fall
   property p_cnt0; // see R18
      (st.ctrl[`DTC_CTRL_RUN0] && !st.mode[`DTC_MODE_GATE0] && st.mode[`DTC_MODE_CT0]
       && st.mode[1:0] == `DTC_MODE_16BIT && st.cnt_prev[0] && !pins.count_input_pin_zero
       && !wr_en && st.tmr[0] != 16'hffff) |=> st.tmr[0] == $past(st.tmr[0]) + 16'h0001;
   endproperty
   a_cnt0: assert property (p_cnt0) else $error("counter did not step on pin fall");

   // Edge mode sets irq 1 flag on a falling edge
   property p_edge1; // see R6
      (st.ctrl[`DTC_CTRL_XEDGE1] && st.irq_prev[1] && !pins.ext_irq_pin_one_n)
      |=> st.ctrl[`DTC_CTRL_XFLAG1];
   endproperty
   a_edge1: assert property (p_edge1) else $error("irq 1 edge missed");

   // Level mode irq 0 flag follows the pin
   property p_level0; // see R8
      !st.ctrl[`DTC_CTRL_XEDGE0] |=> st.ctrl[`DTC_CTRL_XFLAG0] == !$past(pins.ext_irq_pin_zero_n);
   endproperty
   a_level0: assert property (p_level0) else $error("irq 0 level flag wrong");

   // Acknowledge clears timer 1 flag unless an overflow lands at once
   property p_ack1; // see R2
      (wr_en && st.aw_idx == `DTC_IDX_ACK && st.wdata[`DTC_ACK_OVF1] && !ovf[1])
      |=> !st.ctrl[`DTC_CTRL_OVF1];
   endproperty
   a_ack1: assert property (p_ack1) else $error("timer 1 flag not cleared");

endmodule // dtc_top

// *** tb/dtc_pin_model.sv ***
// ----------------------------------------------------------------------
// Far-side pins: two irq pins and two count inputs
// ----------------------------------------------------------------------
module dtc_pin_model (
   input wire logic aclk,
   output dtc_pkg::dtc_pins_type pins
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle: irq pins inactive high, count pins high so a fall is clean
   initial begin
      pins = 4'hf;
   end

   // Falling transitions on a count pin, two cycles low and two high
   task automatic fall_cnt(input int i, input int n);
      repeat (n) begin
         @(posedge aclk);
         pins[i] <= 1'b0;
         repeat (2) @(posedge aclk);
         pins[i] <= 1'b1;
         repeat (2) @(posedge aclk);
      end
   endtask

   // Level on an active-low irq pin, held long enough to be flagged
   task automatic set_irq(input int i, input logic v);
      @(posedge aclk);
      pins[i+2] <= v;
      repeat (2) @(posedge aclk);
   endtask
endmodule // dtc_pin_model

// *** tb/dtc_bench.sv ***
// ----------------------------------------------------------------------
// Bench for the dual timer block
// ----------------------------------------------------------------------
module dtc_bench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [11:0] A_CTRL = 12'h220;
   localparam logic [11:0] A_MODE = 12'h224;
   localparam logic [11:0] A_CNT0_LO = 12'h228;
   localparam logic [11:0] A_CNT1_LO = 12'h22c;
   localparam logic [11:0] A_CNT0_HI = 12'h230;
   localparam logic [11:0] A_CNT1_HI = 12'h234;
   localparam logic [11:0] A_ACK = 12'h238;

   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [11:0] araddr = 12'h000;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   dtc_pkg::dtc_pins_type pins;
   int n_mismatch = 0;
   int n_checks = 0;

   // Clock at 50 MHz
   always #10 aclk = ~aclk;

   dtc_top #(.ADDR_W(12), .MC_CLKS(2)) DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .pins(pins));

   dtc_pin_model u_pins (.aclk(aclk), .pins(pins));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Write one byte register; address and data offered together
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
      check({32'h0, bresp}, {32'h0, er});
      // Let an edge pass so a following call never reassigns bready at once
      @(posedge aclk);
   endtask

   // Read one register and compare response code and data
   task automatic rdchk(input logic [11:0] a, input logic [33:0] e);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
      check({rresp, rdata}, e);
      // Let an edge pass so a following call never reassigns rready at once
      @(posedge aclk);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Reset values and an unmapped place
   task automatic t_reset;
      rdchk(A_CTRL, 34'h0);
      rdchk(A_MODE, 34'h0);
      rdchk(A_CNT1_HI, 34'h0);
      rdchk(12'h23c, {2'b10, 32'h0});
      wr(12'h23c, 8'h55, 2'b10);
   endtask

   // Timer 0 counting pin falls in 16-bit mode across the wrap
   task automatic t_t0_wrap;
      wr(A_MODE, 8'h05, 2'b00);
      wr(A_CNT0_LO, 8'hfe, 2'b00);
      wr(A_CNT0_HI, 8'hff, 2'b00);
      wr(A_CTRL, 8'h10, 2'b00);
      u_pins.fall_cnt(0, 3);
      rdchk(A_CNT0_LO, 34'h01);
      rdchk(A_CNT0_HI, 34'h00);
      rdchk(A_CTRL, 34'h30);
      wr(A_ACK, 8'h04, 2'b00);
      rdchk(A_CTRL, 34'h10);
   endtask

   // Timer 1 in 13-bit mode, prescaler bits roll into the high byte
   task automatic t_t1_mode0;
      wr(A_MODE, 8'h40, 2'b00);
      wr(A_CNT1_LO, 8'h1e, 2'b00);
      wr(A_CNT1_HI, 8'hff, 2'b00);
      wr(A_CTRL, 8'h40, 2'b00);
      u_pins.fall_cnt(1, 1);
      rdchk(A_CNT1_LO, 34'h1f);
      rdchk(A_CTRL, 34'h40);
      u_pins.fall_cnt(1, 1);
      rdchk(A_CNT1_HI, 34'h00);
      rdchk(A_CNT1_LO, 34'h00);
      rdchk(A_CTRL, 34'hc0);
      wr(A_ACK, 8'h08, 2'b00);
      rdchk(A_CTRL, 34'h40);
   endtask

   // Run bit off, then gate held closed by a low irq pin, then open
   task automatic t_gate;
      wr(A_CTRL, 8'h00, 2'b00);
      wr(A_MODE, 8'h0d, 2'b00);
      wr(A_CNT0_LO, 8'h00, 2'b00);
      wr(A_CNT0_HI, 8'h00, 2'b00);
      u_pins.fall_cnt(0, 2);
      rdchk(A_CNT0_LO, 34'h00);
      wr(A_CTRL, 8'h10, 2'b00);
      u_pins.set_irq(0, 1'b0);
      u_pins.fall_cnt(0, 2);
      rdchk(A_CNT0_LO, 34'h00);
      rdchk(A_CTRL, 34'h12);
      u_pins.set_irq(0, 1'b1);
      u_pins.fall_cnt(0, 2);
      rdchk(A_CNT0_LO, 34'h02);
      rdchk(A_CTRL, 34'h10);
   endtask

   // Edge-triggered irq flags latch and clear only on acknowledge
   task automatic t_edge;
      wr(A_CTRL, 8'h05, 2'b00);
      u_pins.set_irq(1, 1'b0);
      u_pins.set_irq(1, 1'b1);
      rdchk(A_CTRL, 34'h0d);
      u_pins.set_irq(0, 1'b0);
      u_pins.set_irq(0, 1'b1);
      rdchk(A_CTRL, 34'h0f);
      wr(A_ACK, 8'h03, 2'b00);
      rdchk(A_CTRL, 34'h05);
      rdchk(A_CNT0_LO, 34'h02);
   endtask

   // Timer function from the core clock overflows from all ones
   task automatic t_timer;
      wr(A_MODE, 8'h01, 2'b00);
      wr(A_CNT0_LO, 8'hff, 2'b00);
      wr(A_CNT0_HI, 8'hff, 2'b00);
      wr(A_CTRL, 8'h10, 2'b00);
      repeat (6) @(posedge aclk);
      rdchk(A_CTRL, 34'h30);
   endtask

   // ----------------------------------------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_t0_wrap();
      t_t1_mode0();
      t_gate();
      t_edge();
      t_timer();
      finish_test();
   end

   // Cuts a hang well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      finish_test();
   end
endmodule // dtc_bench
